// ### ascr_rx_qualifier.sv
`timescale 1ns/1ps
module ascr_rx_qualifier #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              serial_in,
    input  wire logic              rx_bit_clock,
    output logic                   rx_char_available,
    output logic                   irq
);
    // mask of valid data bits for a 5..8 bit character
    function automatic logic [7:0] len_mask(input logic [1:0] len);
        case (len)
            2'h0:    len_mask = 8'h1f;
            2'h1:    len_mask = 8'h3f;
            2'h2:    len_mask = 8'h7f;
            default: len_mask = 8'hff;
        endcase
    endfunction

    logic [1:0]  pin_s;
    logic        rxd;
    logic        rxc_s;
    logic        rxc_d_reg;
    logic        rxc_d_next;
    logic        tick;

    // both pins come from outside the clock domain
    ascr_sync2 #(.WIDTH(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({rx_bit_clock, serial_in}),
        .q       (pin_s)
    );
    assign rxd   = pin_s[0];
    assign rxc_s = pin_s[1];

    // receiver clock rising edge becomes a one-cycle enable
    always_comb begin
        rxc_d_next = rxc_s;
        tick       = rxc_s & ~rxc_d_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxc_d_reg <= 1'b1;
        end else begin
            rxc_d_reg <= rxc_d_next;
        end
    end

    // control register fields
    logic [ascr_pkg::CTRL_W-1:0] ctrl_reg;
    logic [ascr_pkg::CTRL_W-1:0] ctrl_next;
    logic       en;
    logic       x64;
    logic [1:0] clen;
    logic       pen;
    logic       peven;
    logic [6:0] factor;
    logic [6:0] accept;
    logic [2:0] last_idx;

    always_comb begin
        en       = ctrl_reg[ascr_pkg::CTRL_EN_BIT];
        x64      = ctrl_reg[ascr_pkg::CTRL_X64_BIT];
        clen     = ctrl_reg[ascr_pkg::CTRL_LEN_LSB +: 2];
        pen      = ctrl_reg[ascr_pkg::CTRL_PEN_BIT];
        peven    = ctrl_reg[ascr_pkg::CTRL_EVEN_BIT];
        factor   = x64 ? ascr_pkg::X64_FACTOR : ascr_pkg::X16_FACTOR;
        accept   = x64 ? ascr_pkg::X64_ACCEPT : ascr_pkg::X16_ACCEPT;
        last_idx = 3'h4 + {1'b0, clen};
    end

    // receiver state
    ascr_pkg::ascr_state_t st_reg, st_next;
    logic [6:0] ph_reg, ph_next;
    logic [6:0] bcnt_reg, bcnt_next;
    logic [2:0] bidx_reg, bidx_next;
    logic [7:0] sh_reg, sh_next;
    logic       par_reg, par_next;
    logic       zeros_reg, zeros_next;
    logic       brk_reg, brk_next;
    logic       centre;
    logic       load;
    logic       ev_char;
    logic       ev_perr;
    logic       ev_ferr;
    logic       ev_oerr;
    logic       mismatch;
    logic       rd_data;
    logic       avail_reg;

    // frame sequencer, advanced on receiver clock edges, forced to idle in any cycle while disabled
    always_comb begin
        st_next    = st_reg;
        ph_next    = ph_reg;
        bcnt_next  = bcnt_reg;
        bidx_next  = bidx_reg;
        sh_next    = sh_reg;
        par_next   = par_reg;
        zeros_next = zeros_reg;
        brk_next   = brk_reg;
        load       = 1'b0;
        ev_char    = 1'b0;
        ev_perr    = 1'b0;
        ev_ferr    = 1'b0;
        ev_oerr    = 1'b0;
        centre     = (bcnt_reg == factor - 7'h01);
        mismatch   = (^(sh_reg & len_mask(clen))) ^ par_reg ^ ~peven;
        if (!en) begin
            st_next  = ascr_pkg::ASCR_IDLE;
            brk_next = 1'b0;
        end else if (tick) begin
            if (st_reg != ascr_pkg::ASCR_IDLE && st_reg != ascr_pkg::ASCR_START) begin
                bcnt_next = centre ? 7'h00 : bcnt_reg + 7'h01;
            end
            case (st_reg)
                ascr_pkg::ASCR_IDLE: begin
                    if (!rxd) begin
                        ph_next = 7'h01;
                        st_next = ascr_pkg::ASCR_START;
                    end else begin
                        brk_next = 1'b0; // line high again ends any break
                    end
                end
                ascr_pkg::ASCR_START: begin
                    if (rxd) begin
                        st_next = ascr_pkg::ASCR_IDLE;
                    end else if (ph_reg + 7'h01 == accept) begin
                        // accept point sits one clock past the start centre
                        st_next    = ascr_pkg::ASCR_DATA;
                        bcnt_next  = accept - (factor >> 1);
                        bidx_next  = 3'h0;
                        zeros_next = 1'b1;
                    end else begin
                        ph_next = ph_reg + 7'h01;
                    end
                end
                ascr_pkg::ASCR_DATA: begin
                    if (centre) begin
                        sh_next[bidx_reg] = rxd;
                        zeros_next        = zeros_reg & ~rxd;
                        if (bidx_reg == last_idx) begin
                            st_next = pen ? ascr_pkg::ASCR_PAR : ascr_pkg::ASCR_STOP;
                        end else begin
                            bidx_next = bidx_reg + 3'h1;
                        end
                    end
                end
                ascr_pkg::ASCR_PAR: begin
                    if (centre) begin
                        par_next   = rxd;
                        zeros_next = zeros_reg & ~rxd;
                        if (brk_reg && zeros_reg && rxd) begin
                            // break released just before parity: flag only
                            ev_perr  = 1'b1;
                            brk_next = 1'b0;
                            st_next  = ascr_pkg::ASCR_IDLE;
                        end else begin
                            st_next = ascr_pkg::ASCR_STOP;
                        end
                    end
                end
                ascr_pkg::ASCR_STOP: begin
                    if (centre) begin
                        st_next = ascr_pkg::ASCR_IDLE;
                        if (brk_reg) begin
                            brk_next = zeros_reg & ~rxd;
                        end else if (zeros_reg && !rxd) begin
                            brk_next = 1'b1;
                        end else begin
                            load    = 1'b1;
                            ev_char = 1'b1;
                            ev_perr = pen & mismatch;
                            ev_ferr = ~rxd;
                            ev_oerr = avail_reg & ~rd_data;
                        end
                    end
                end
                default: st_next = ascr_pkg::ASCR_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg    <= ascr_pkg::ASCR_IDLE;
            ph_reg    <= 7'h00;
            bcnt_reg  <= 7'h00;
            bidx_reg  <= 3'h0;
            sh_reg    <= 8'h00;
            par_reg   <= 1'b0;
            zeros_reg <= 1'b0;
            brk_reg   <= 1'b0;
        end else begin
            st_reg    <= st_next;
            ph_reg    <= ph_next;
            bcnt_reg  <= bcnt_next;
            bidx_reg  <= bidx_next;
            sh_reg    <= sh_next;
            par_reg   <= par_next;
            zeros_reg <= zeros_next;
            brk_reg   <= brk_next;
        end
    end

    // apb decode
    logic        acc;
    logic        wr;
    logic        err_rst;
    logic        hit;
    logic [11:0] a;
    logic [31:0] rd_val;
    logic [31:0] prdata_next;
    logic [7:0]  data_reg, data_next;
    logic        avail_next;
    logic        perr_reg, perr_next;
    logic        ferr_reg, ferr_next;
    logic        oerr_reg, oerr_next;
    logic [ascr_pkg::IRQ_N-1:0] irq_stat;
    logic [ascr_pkg::IRQ_N-1:0] irq_mask;

    always_comb begin
        a       = 12'(paddr);
        acc     = psel & penable;
        wr      = acc & pwrite;
        hit     = 1'b1;
        rd_val  = 32'h0000_0000;
        if (a == ascr_pkg::OFS_DATA) begin
            rd_val = {24'h00_0000, data_reg};
        end else if (a == ascr_pkg::OFS_CTRL) begin
            rd_val = {26'h000_0000, ctrl_reg};
        end else if (a == ascr_pkg::OFS_STATUS) begin
            rd_val = {27'h000_0000, brk_reg, ferr_reg, oerr_reg, perr_reg, avail_reg};
        end else if (a == ascr_pkg::OFS_CMD) begin
            rd_val = 32'h0000_0000;
        end else if (a == ascr_pkg::OFS_IRQ_STAT) begin
            rd_val = {28'h000_0000, irq_stat};
        end else if (a == ascr_pkg::OFS_IRQ_MASK) begin
            rd_val = {28'h000_0000, irq_mask};
        end else begin
            hit = 1'b0;
        end
        // read data is captured in the setup cycle so prdata is a flop
        prdata_next = (psel & ~penable & ~pwrite) ? rd_val : prdata;
        rd_data     = acc & ~pwrite & (a == ascr_pkg::OFS_DATA);
        err_rst     = wr & (a == ascr_pkg::OFS_CMD) & pwdata[ascr_pkg::CMD_ERR_RST_BIT];
        ctrl_next   = (wr && a == ascr_pkg::OFS_CTRL) ? pwdata[ascr_pkg::CTRL_W-1:0] : ctrl_reg;
    end

    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;

    // received byte and error flags; a setting event wins over a clear
    always_comb begin
        data_next  = load ? (sh_reg & len_mask(clen)) : data_reg;
        avail_next = (avail_reg & ~rd_data) | load;
        perr_next  = (perr_reg & ~err_rst) | ev_perr;
        ferr_next  = (ferr_reg & ~err_rst) | ev_ferr;
        oerr_next  = (oerr_reg & ~err_rst) | ev_oerr;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= ascr_pkg::CTRL_RESET;
            prdata    <= 32'h0000_0000;
            data_reg  <= 8'h00;
            avail_reg <= 1'b0;
            perr_reg  <= 1'b0;
            ferr_reg  <= 1'b0;
            oerr_reg  <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            prdata    <= prdata_next;
            data_reg  <= data_next;
            avail_reg <= avail_next;
            perr_reg  <= perr_next;
            ferr_reg  <= ferr_next;
            oerr_reg  <= oerr_next;
        end
    end

    assign rx_char_available = avail_reg;

    ascr_irq #(.N(ascr_pkg::IRQ_N)) u_irq (
        .pclk       (pclk),
        .presetn    (presetn),
        .ev_set     ({ev_oerr, ev_ferr, ev_perr, ev_char}),
        .stat_wr    (wr && a == ascr_pkg::OFS_IRQ_STAT),
        .stat_w1c   (pwdata[ascr_pkg::IRQ_N-1:0]),
        .mask_wr    (wr && a == ascr_pkg::OFS_IRQ_MASK),
        .mask_wdata (pwdata[ascr_pkg::IRQ_N-1:0]),
        .stat_reg   (irq_stat),
        .mask_reg   (irq_mask),
        .irq        (irq)
    );
endmodule // ascr_rx_qualifier

// ### ascr_pkg.sv
// Overview of operation
// - x16 factor: low pulses shorter than 7 receiver clocks are ignored, no assembly.
// - x64 factor: low pulses shorter than 31 receiver clocks are discarded as spurious.
// - x16 factor: a low of 9 to 16 receiver clocks is a valid start bit.
// - x64 factor: a low of 33 to 64 receiver clocks is a genuine start bit.
// - break ending between last data bit and parity sets parity error, no ready.
// - that parity error stays set through the next normal character.
// - break ending elsewhere sets no parity error and raises no ready.
// - a genuine parity mismatch sets the parity error and raises ready.
// - ready rises within 26 main clocks of the final bit centre.
package ascr_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_DATA     = 12'h000;
    localparam logic [11:0] OFS_CTRL     = 12'h004;
    localparam logic [11:0] OFS_STATUS   = 12'h008;
    localparam logic [11:0] OFS_CMD      = 12'h00c;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h010;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h014;
    // control fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_X64_BIT  = 1;
    localparam int CTRL_LEN_LSB  = 2;
    localparam int CTRL_PEN_BIT  = 4;
    localparam int CTRL_EVEN_BIT = 5;
    localparam int CTRL_W        = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // command fields
    localparam int CMD_ERR_RST_BIT = 0;
    // status fields
    localparam int STAT_AVAIL_BIT = 0;
    localparam int STAT_PERR_BIT  = 1;
    localparam int STAT_OERR_BIT  = 2;
    localparam int STAT_FERR_BIT  = 3;
    localparam int STAT_BRK_BIT   = 4;
    // interrupt event bits
    localparam int IRQ_CHAR_BIT = 0;
    localparam int IRQ_PERR_BIT = 1;
    localparam int IRQ_FERR_BIT = 2;
    localparam int IRQ_OERR_BIT = 3;
    localparam int IRQ_N        = 4;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    // baud factors and start qualification points, in receiver clocks
    localparam logic [6:0] X16_FACTOR = 7'h10;
    localparam logic [6:0] X64_FACTOR = 7'h40;
    localparam logic [6:0] X16_ACCEPT = 7'h09;
    localparam logic [6:0] X64_ACCEPT = 7'h21;
    // latency bounds in main clock cycles
    localparam int RDY_MAX_CYC    = 26;
    localparam int STATUS_LAG_CYC = 28;

    typedef enum logic [2:0] {
        ASCR_IDLE  = 3'b000,
        ASCR_START = 3'b001,
        ASCR_DATA  = 3'b010,
        ASCR_PAR   = 3'b011,
        ASCR_STOP  = 3'b100
    } ascr_state_t;
endpackage

// ### ascr_sync2.sv
`timescale 1ns/1ps
module ascr_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_next;

    // first stage feeds only the second stage
    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    // idle line is high, so both stages reset to ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '1;
            q        <= '1;
        end else begin
            meta_reg <= meta_next;
            q        <= q_next;
        end
    end
endmodule // ascr_sync2

// ### ascr_irq.sv
`timescale 1ns/1ps
module ascr_irq #(
    parameter int N = 4
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] ev_set,
    input  wire logic         stat_wr,
    input  wire logic [N-1:0] stat_w1c,
    input  wire logic         mask_wr,
    input  wire logic [N-1:0] mask_wdata,
    output logic      [N-1:0] stat_reg,
    output logic      [N-1:0] mask_reg,
    output logic              irq
);
    logic [N-1:0] stat_next;
    logic [N-1:0] mask_next;

    // write-one-to-clear; an event in the clearing cycle wins
    always_comb begin
        stat_next = stat_reg;
        if (stat_wr) begin
            stat_next = stat_next & ~stat_w1c;
        end
        stat_next = stat_next | ev_set;
        mask_next = mask_wr ? mask_wdata : mask_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= '0;
            mask_reg <= '0;
        end else begin
            stat_reg <= stat_next;
            mask_reg <= mask_next;
        end
    end

    // level output, high while any unmasked event is pending
    assign irq = |(stat_reg & mask_reg);
endmodule // ascr_irq

// ### ascr_rx_assertions.sv
`timescale 1ns/1ps
module ascr_rx_assertions #(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              serial_in,
    input wire logic              rx_bit_clock,
    input wire logic              rx_char_available,
    input wire logic              irq
);
    logic [5:0] since_reg, since_next;
    logic       prev_reg, prev_next, en_reg, en_next;
    logic [3:0] msk_reg, msk_next;
    logic       acc, rd_data, mapped;
    assign acc     = psel && penable;
    assign rd_data = acc && !pwrite && paddr == ascr_pkg::OFS_DATA;
    assign mapped  = paddr inside {ascr_pkg::OFS_DATA, ascr_pkg::OFS_CTRL, ascr_pkg::OFS_STATUS,
                                   ascr_pkg::OFS_CMD, ascr_pkg::OFS_IRQ_STAT,
                                   ascr_pkg::OFS_IRQ_MASK};
    // shadow of enable and mask, plus cycles since the last receiver clock pin rise
    always_comb begin
        prev_next  = rx_bit_clock;
        since_next = (rx_bit_clock && !prev_reg) ? 6'h00 :
                     (since_reg == 6'h3f) ? since_reg : since_reg + 6'h01;
        en_next    = en_reg;
        msk_next   = msk_reg;
        if (acc && pwrite && paddr == ascr_pkg::OFS_CTRL) en_next = pwdata[0];
        if (acc && pwrite && paddr == ascr_pkg::OFS_IRQ_MASK) msk_next = pwdata[3:0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_reg <= 6'h3f;
            prev_reg  <= 1'b1;
            en_reg    <= 1'b0;
            msk_reg   <= 4'h0;
        end else begin
            since_reg <= since_next;
            prev_reg  <= prev_next;
            en_reg    <= en_next;
            msk_reg   <= msk_next;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY_HIGH: assert property (psel |-> pready)
        else $error("pready low during a transfer");
    AST_UNMAPPED_ERR: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    AST_MAPPED_OK: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped access");
    AST_IDLE_NO_ERR: assert property (!acc |-> !pslverr)
        else $error("error outside access phase");
    AST_READY_LAG: assert property ($rose(rx_char_available) |-> since_reg <= 6'h1a)
        else $error("ready too late after bit clock");
    // a completing character can only load in the cycle one after a synced tick edge
    AST_READ_CLEARS: assert property (rd_data && since_reg != 6'h01 |=> !rx_char_available)
        else $error("data read did not clear ready");
    AST_READY_HOLDS: assert property (rx_char_available && !rd_data |=> rx_char_available)
        else $error("ready dropped without a read");
    AST_NO_RX_DISABLED: assert property ($rose(rx_char_available) |-> $past(en_reg, 2))
        else $error("character while receiver disabled");
    AST_IRQ_MASKED: assert property (msk_reg == 4'h0 |-> !irq)
        else $error("interrupt with all sources masked");
    COV_CHAR: cover property ($rose(rx_char_available));
    COV_UNMAPPED: cover property (acc && !mapped);
    COV_IRQ: cover property ($rose(irq));
endmodule // ascr_rx_assertions

bind ascr_rx_qualifier ascr_rx_assertions #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in(serial_in), .rx_bit_clock(rx_bit_clock),
    .rx_char_available(rx_char_available), .irq(irq));

// ### ascr_line_model.sv
`timescale 1ns/1ps
module ascr_line_model (
    output logic serial_in,
    output logic rx_bit_clock
);
    // receiver clock runs free at 8 pclk per tick, well inside the sampler limits
    initial rx_bit_clock = 1'b0;
    initial serial_in = 1'b1;
    always #16 rx_bit_clock = ~rx_bit_clock;
    // line changes on the falling clock edge, far from the sampling rise
    task automatic hold(input logic v, input int n);
        serial_in <= v;
        repeat (n) @(posedge rx_bit_clock);
        @(negedge rx_bit_clock);
    endtask
    // callers never ask for 8 or 32 tick starts: those lengths are unsafe
    task automatic frame(input int st, input logic [7:0] d, input logic p, input logic x64);
        int f;
        f = x64 ? 64 : 16;
        hold(1'b0, st);
        for (int i = 0; i < 8; i++) hold(d[i], f);
        hold(p, f);
        hold(1'b1, f);
    endtask
endmodule // ascr_line_model

// ### test_async_rx_start_bit_qualifier.sv
`timescale 1ns/1ps
module test_async_rx_start_bit_qualifier;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, serial_in, rx_bit_clock, rx_char_available, irq, er;
    int          miscompares = 0, n_tests = 0, cyc = 0;
    ascr_line_model m (.serial_in(serial_in), .rx_bit_clock(rx_bit_clock));
    ascr_rx_qualifier dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_in(serial_in), .rx_bit_clock(rx_bit_clock),
        .rx_char_available(rx_char_available), .irq(irq));
    always #2 pclk = ~pclk;
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // long waits are line frames; the ceiling leaves twice the expected run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one apb transfer; an idle edge follows so strobes never toggle twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(ascr_pkg::OFS_STATUS, 32'h0);
        rdc(ascr_pkg::OFS_IRQ_MASK, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, er}, 32'h1);
        done("reset");
        apb(1'b1, ascr_pkg::OFS_CTRL, 32'h3d);
        apb(1'b1, ascr_pkg::OFS_IRQ_MASK, 32'h1);
        m.hold(1'b0, 7);
        m.hold(1'b1, 40);
        rdc(ascr_pkg::OFS_STATUS, 32'h0);
        m.frame(9, 8'ha5, ^8'ha5, 1'b0);
        rdc(ascr_pkg::OFS_STATUS, 32'h1);
        chk({31'h0, rx_char_available}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ascr_pkg::OFS_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ascr_pkg::OFS_IRQ_MASK, 32'h1);
        apb(1'b1, ascr_pkg::OFS_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rdc(ascr_pkg::OFS_DATA, 32'ha5);
        rdc(ascr_pkg::OFS_STATUS, 32'h0);
        chk({31'h0, rx_char_available}, 32'h0);
        done("x16 start");
        apb(1'b1, ascr_pkg::OFS_CTRL, 32'h3f);
        m.hold(1'b0, 31);
        m.hold(1'b1, 80);
        rdc(ascr_pkg::OFS_STATUS, 32'h0);
        m.frame(33, 8'h3c, ^8'h3c, 1'b1);
        rdc(ascr_pkg::OFS_STATUS, 32'h1);
        rdc(ascr_pkg::OFS_DATA, 32'h3c);
        done("x64 start");
        apb(1'b1, ascr_pkg::OFS_CTRL, 32'h3d);
        m.frame(16, 8'h81, ~^8'h81, 1'b0);
        rdc(ascr_pkg::OFS_STATUS, 32'h3);
        rdc(ascr_pkg::OFS_DATA, 32'h81);
        rdc(ascr_pkg::OFS_STATUS, 32'h2);
        apb(1'b1, ascr_pkg::OFS_CMD, 32'h1);
        rdc(ascr_pkg::OFS_STATUS, 32'h0);
        done("parity");
        // break rising between the second frame's last data bit and its parity bit
        m.hold(1'b0, 312);
        m.hold(1'b1, 40);
        rdc(ascr_pkg::OFS_STATUS, 32'h2);
        m.frame(16, 8'h55, ^8'h55, 1'b0);
        rdc(ascr_pkg::OFS_STATUS, 32'h3);
        rdc(ascr_pkg::OFS_DATA, 32'h55);
        apb(1'b1, ascr_pkg::OFS_CMD, 32'h1);
        m.hold(1'b0, 340);
        m.hold(1'b1, 40);
        rdc(ascr_pkg::OFS_STATUS, 32'h0);
        done("break");
        end_of_test();
    end
endmodule // test_async_rx_start_bit_qualifier
